// ==== src/cpm_regs.vh ====
// Register map, field positions and timing constants of the PWM/mode-control block.
// Assumes a plain register port with byte-wide data in the low bits.
`ifndef CPM_REGS_VH
`define CPM_REGS_VH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define CPM_A_TB_COUNT    4'h0
`define CPM_A_PERIOD      4'h1
`define CPM_A_TB_CTRL     4'h2
`define CPM_A_U1_NEXT     4'h3
`define CPM_A_U1_ACTIVE   4'h4
`define CPM_A_U1_CTRL     4'h5
`define CPM_A_U2_NEXT     4'h6
`define CPM_A_U2_ACTIVE   4'h7
`define CPM_A_U2_CTRL     4'h8
`define CPM_A_SHUTDOWN    4'h9
`define CPM_A_DEADBAND    4'hA
`define CPM_A_CAPT_LO     4'hB
`define CPM_A_CAPT_HI     4'hC
`define CPM_A_STATUS      4'hD
// ------------------------------------------------------------
// Fields
// ------------------------------------------------------------
`define CPM_F_OCFG_HI     7
`define CPM_F_OCFG_LO     6
`define CPM_F_DLOW_HI     5
`define CPM_F_DLOW_LO     4
`define CPM_F_MODE_HI     3
`define CPM_F_MODE_LO     0
`define CPM_F_TB_ON       2
`define CPM_F_PS_HI       1
`define CPM_F_PS_LO       0
`define CPM_F_SD_EVENT    7
`define CPM_F_DB_HI       6
`define CPM_F_DB_LO       0
// ------------------------------------------------------------
// Mode codes
// ------------------------------------------------------------
`define CPM_M_OFF         4'h0
`define CPM_M_CMP_TOGGLE  4'h2
`define CPM_M_CAPT_FALL   4'h4
`define CPM_M_CAPT_RISE   4'h5
`define CPM_M_CAPT_R4     4'h6
`define CPM_M_CAPT_R16    4'h7
`define CPM_M_CMP_SET     4'h8
`define CPM_M_CMP_CLR     4'h9
`define CPM_M_CMP_SOFT    4'hA
`define CPM_M_CMP_TRIG    4'hB
`define CPM_M_PWM_HI2     2'h3
`define CPM_OC_SINGLE     2'h0
`define CPM_OC_FWD        2'h1
`define CPM_OC_HALF       2'h2
`define CPM_OC_REV        2'h3
`define CPM_PS_DIV1       2'h0
`define CPM_PS_DIV4       2'h1
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CPM_OSC_PER_INSTR 2'h3
`define CPM_RESET_CTRL    8'h00
`endif

// ==== src/cpm_pwm_mode_control.v ====
// PWM datapath with two capture/compare/PWM units sharing one timebase and one capture timer.
// Assumes ref_clk stands for the oscillator; four cycles form one instruction cycle.
// Operation
// RULE1 - PWM output with up to ten-bit duty resolution.
// RULE2 - Period is (period_limit+1) times four oscillator cycles times prescale.
// RULE3 - Prescaler divides by 1, 4 or 16 only.
// RULE4 - Counter equal to period_limit clears on next increment.
// RULE5 - Rollover drives output high unless duty is zero.
// RULE6 - Rollover copies next duty byte and low bits into active buffer.
// RULE7 - Duty is next byte as upper eight bits, control bits 5:4 lower.
// RULE8 - High time is duty times oscillator period times prescale.
// RULE9 - Duty writes accepted anytime; active byte read-only in PWM mode.
// RULE10 - Output clears when buffered duty equals counter extended by two bits.
// RULE11 - Duty beyond period keeps output high whole period.
// RULE12 - Second unit has no automatic shutdown; first unit does.
// RULE13 - Software sets period, duty, pin, prescale, then PWM mode.
// RULE14 - Capture/compare use capture timer; PWM uses the timebase.
// RULE15 - Outside PWM, output A does capture/compare; B, C, D revert to port.
// RULE16 - output_config selects single, forward, half-bridge or reverse steering.
// RULE17 - Mode 0000 off and reset, 0001 reserved, 0011 capture; code gives 0011 no capture or compare action.
// RULE18 - Modes 0100-0111 capture falling, rising, fourth, sixteenth rising edge.
// RULE19 - Compare modes toggle, set, or clear pin on match; match sets flag.
// RULE20 - 1010 flag only, pin to port; 1011 resets capture timer, sets flag.
// RULE21 - Modes 11xx are PWM; bit1 inverts A and C, bit0 B and D.
// RULE22 - Half-bridge dead-band delays each output going active by count.
// RULE23 - Fine bits come from oscillator phase at divide-by-one, else prescaler.
`include "cpm_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module cpm_pwm_mode_control #(
   parameter DW = 8
) (
   input  wire          ref_clk,
   input  wire          rstn,
   input  wire [3:0]    addr,
   input  wire [DW-1:0] wdata,
   input  wire          wr,
   input  wire          rd,
   output reg  [DW-1:0] rdata,
   input  wire          capt_pin1,
   input  wire          capt_pin2,
   input  wire          shutdown_in,
   output reg           output_a,
   output reg           output_b,
   output reg           output_c,
   output reg           output_d,
   output reg  [3:0]    out_en,
   output reg           unit2_out,
   output reg           unit2_en,
   output reg           match_flag1,
   output reg           match_flag2,
   output reg           special_event
);
   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   reg [7:0]  timebase_counter;
   reg [7:0]  period_limit;
   reg [7:0]  timebase_control;
   reg [7:0]  u1_next;
   reg [7:0]  u1_active;
   reg [7:0]  u1_ctrl;
   reg [7:0]  u2_next;
   reg [7:0]  u2_active;
   reg [7:0]  u2_ctrl;
   reg [7:0]  shutdown_control;
   reg [7:0]  deadband_delay;
   reg [1:0]  u1_lat;
   reg [1:0]  u2_lat;
   reg [1:0]  osc_phase;
   reg [3:0]  prescale;
   reg [15:0] capture_timer;
   reg        pwm1;
   reg        pwm2;
   reg        cmp1;
   reg        cmp2;
   reg [6:0]  db_cnt;
   reg        pwm1_q;
   reg [3:0]  cap1_div;
   reg [3:0]  cap2_div;
   reg [2:0]  s1;
   reg [2:0]  s2;
   reg [2:0]  ssd;
   reg        s1_old;
   reg        s2_old;
   reg        sd_old;
   reg        rollover_q;
   wire [3:0] mode1 = u1_ctrl[`CPM_F_MODE_HI:`CPM_F_MODE_LO];
   wire [3:0] mode2 = u2_ctrl[`CPM_F_MODE_HI:`CPM_F_MODE_LO];
   wire [1:0] ocfg  = u1_ctrl[`CPM_F_OCFG_HI:`CPM_F_OCFG_LO];
   wire       pwm_mode1 = (mode1[3:2] == `CPM_M_PWM_HI2);        // see RULE21
   wire       pwm_mode2 = (mode2[3:2] == `CPM_M_PWM_HI2);
   wire       tb_on = timebase_control[`CPM_F_TB_ON];
   wire [1:0] ps_sel = timebase_control[`CPM_F_PS_HI:`CPM_F_PS_LO];
   wire       instr_tick = (osc_phase == `CPM_OSC_PER_INSTR);
   // Prescaler terminal: only 1, 4, 16 exist; codes 2 and 3 both give 16
   function ps_done;
      input [1:0] sel;
      input [3:0] cnt;
      begin
         if (sel == `CPM_PS_DIV1)
            ps_done = 1'b1;
         else if (sel == `CPM_PS_DIV4)
            ps_done = (cnt[1:0] == 2'h3);
         else
            ps_done = (cnt == 4'hF);
      end
   endfunction
   // Fine bits extend the counter to ten bits
   function [1:0] fine_bits;
      input [1:0] sel;
      input [1:0] ph;
      input [3:0] cnt;
      begin
         if (sel == `CPM_PS_DIV1)
            fine_bits = ph;                                            // see RULE23
         else if (sel == `CPM_PS_DIV4)
            fine_bits = cnt[1:0];
         else
            fine_bits = cnt[3:2];
      end
   endfunction
   // Capture edge qualification per mode
   function capt_hit;
      input [3:0] m;
      input       rise;
      input       fall;
      input [3:0] div;
      begin
         case (m)
            `CPM_M_CAPT_FALL: capt_hit = fall;                          // see RULE18
            `CPM_M_CAPT_RISE: capt_hit = rise;
            `CPM_M_CAPT_R4:   capt_hit = rise && (div[1:0] == 2'h3);
            `CPM_M_CAPT_R16:  capt_hit = rise && (div == 4'hF);
            default:          capt_hit = 1'b0;
         endcase
      end
   endfunction
   // Compare matches and increment strobe
   wire       tb_inc   = tb_on && instr_tick && ps_done(ps_sel, prescale);  // see RULE2
   wire       rollover = tb_inc && (timebase_counter == period_limit);       // see RULE4
   wire [9:0] tb_ext   = {timebase_counter, fine_bits(ps_sel, osc_phase, prescale)};  // see RULE1, RULE8
   wire       m1_clr   = ({u1_active, u1_lat} == tb_ext);                    // see RULE10
   wire       m2_clr   = ({u2_active, u2_lat} == tb_ext);
   wire       cmp_is1  = (mode1 == `CPM_M_CMP_TOGGLE) || (mode1[3:2] == 2'h2);
   wire       cmp_is2  = (mode2 == `CPM_M_CMP_TOGGLE) || (mode2[3:2] == 2'h2);
   wire       hit1     = cmp_is1 && instr_tick && (capture_timer == {u1_active, u1_next});
   wire       hit2     = cmp_is2 && instr_tick && (capture_timer == {u2_active, u2_next});
   wire       rise1    = (s1[1] == s1[2]) && s1[2] && !s1_old;
   wire       fall1    = (s1[1] == s1[2]) && !s1[2] && s1_old;
   wire       rise2    = (s2[1] == s2[2]) && s2[2] && !s2_old;
   wire       fall2    = (s2[1] == s2[2]) && !s2[2] && s2_old;
   wire       cap1     = capt_hit(mode1, rise1, fall1, cap1_div);             // see RULE14
   wire       cap2     = capt_hit(mode2, rise2, fall2, cap2_div);
   wire       sd_now   = (ssd[1] == ssd[2]) ? ssd[2] : sd_old;
   wire       sd_active = shutdown_control[`CPM_F_SD_EVENT];

   // ------------------------------------------------------------
   // Input synchronisers, three stages, second and third must agree
   // ------------------------------------------------------------
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s1 <= 3'h0;
         s2 <= 3'h0;
         ssd <= 3'h0;
         s1_old <= 1'b0;
         s2_old <= 1'b0;
         sd_old <= 1'b0;
      end else begin
         s1 <= {s1[1:0], capt_pin1};
         s2 <= {s2[1:0], capt_pin2};
         ssd <= {ssd[1:0], shutdown_in};
         s1_old <= (s1[1] == s1[2]) ? s1[2] : s1_old;
         s2_old <= (s2[1] == s2[2]) ? s2[2] : s2_old;
         sd_old <= sd_now;
      end
   end
   // ------------------------------------------------------------
   // Timebase, prescaler, oscillator phase and capture timer
   // ------------------------------------------------------------
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         osc_phase <= 2'h0;
         prescale <= 4'h0;
         timebase_counter <= 8'h00;
         capture_timer <= 16'h0000;
      end else begin
         osc_phase <= osc_phase + 2'h1;
         prescale <= prescale + {3'h0, tb_on && instr_tick};           // see RULE3
         if (wr && addr == `CPM_A_TB_COUNT)
            timebase_counter <= wdata[7:0];
         else if (rollover)
            timebase_counter <= 8'h00;                                  // see RULE4
         else if (tb_inc)
            timebase_counter <= timebase_counter + 8'h01;
         // Trigger mode shares the timer, so a reset wins over counting
         if ((hit1 && mode1 == `CPM_M_CMP_TRIG) || (hit2 && mode2 == `CPM_M_CMP_TRIG))
            capture_timer <= 16'h0000;                                  // see RULE20
         else if (instr_tick)
            capture_timer <= capture_timer + 16'h0001;
      end
   end
   // ------------------------------------------------------------
   // Register writes, duty buffering and captures
   // ------------------------------------------------------------
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         period_limit <= 8'hFF;
         timebase_control <= `CPM_RESET_CTRL;
         u1_next <= 8'h00;
         u1_active <= 8'h00;
         u1_ctrl <= `CPM_RESET_CTRL;
         u2_next <= 8'h00;
         u2_active <= 8'h00;
         u2_ctrl <= `CPM_RESET_CTRL;
         shutdown_control <= 8'h00;
         deadband_delay <= 8'h00;
         u1_lat <= 2'h0;
         u2_lat <= 2'h0;
         cap1_div <= 4'h0;
         cap2_div <= 4'h0;
      end else begin
         if (wr && addr == `CPM_A_PERIOD)
            period_limit <= wdata[7:0];
         if (wr && addr == `CPM_A_TB_CTRL)
            timebase_control <= wdata[7:0];
         if (wr && addr == `CPM_A_U1_NEXT)
            u1_next <= wdata[7:0];                                      // see RULE9
         if (wr && addr == `CPM_A_U1_CTRL)
            u1_ctrl <= wdata[7:0];
         if (wr && addr == `CPM_A_U2_NEXT)
            u2_next <= wdata[7:0];
         if (wr && addr == `CPM_A_U2_CTRL)
            u2_ctrl <= {2'h0, wdata[5:0]};
         if (wr && addr == `CPM_A_DEADBAND)
            deadband_delay <= wdata[7:0];
         // Hardware shutdown event wins over a software clear: it is assigned last
         if (wr && addr == `CPM_A_SHUTDOWN)
            shutdown_control <= wdata[7:0];
         if (pwm_mode1 && sd_now)
            shutdown_control[`CPM_F_SD_EVENT] <= 1'b1;                  // see RULE12
         // Active byte: loaded at rollover in PWM, captured otherwise
         if (pwm_mode1 && rollover) begin
            u1_active <= u1_next;                                       // see RULE6
            u1_lat <= u1_ctrl[`CPM_F_DLOW_HI:`CPM_F_DLOW_LO];           // see RULE7
         end else if (cap1) begin
            u1_active <= capture_timer[15:8];
            u1_next <= capture_timer[7:0];
         end else if (!pwm_mode1 && wr && addr == `CPM_A_U1_ACTIVE)
            u1_active <= wdata[7:0];                                    // see RULE9
         if (pwm_mode2 && rollover) begin
            u2_active <= u2_next;
            u2_lat <= u2_ctrl[`CPM_F_DLOW_HI:`CPM_F_DLOW_LO];
         end else if (cap2) begin
            u2_active <= capture_timer[15:8];
            u2_next <= capture_timer[7:0];
         end else if (!pwm_mode2 && wr && addr == `CPM_A_U2_ACTIVE)
            u2_active <= wdata[7:0];
         // Off clears the capture prescaler
         cap1_div <= (mode1[3:2] != 2'h1) ? 4'h0 : cap1_div + {3'h0, rise1};   // see RULE17
         cap2_div <= (mode2[3:2] != 2'h1) ? 4'h0 : cap2_div + {3'h0, rise2};
      end
   end
   // ------------------------------------------------------------
   // PWM and compare waveform state
   // ------------------------------------------------------------
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pwm1 <= 1'b0;
         pwm2 <= 1'b0;
         cmp1 <= 1'b0;
         cmp2 <= 1'b0;
         pwm1_q <= 1'b0;
         rollover_q <= 1'b0;
         db_cnt <= 7'h00;
         match_flag1 <= 1'b0;
         match_flag2 <= 1'b0;
         special_event <= 1'b0;
      end else begin
         // Set one cycle after rollover, once the buffer holds the new duty, so the high time
         // is exactly the duty count; a match clears it, no match keeps it high
         pwm1 <= rollover_q ? ({u1_active, u1_lat} != 10'h000) : (pwm1 && !m1_clr);  // see RULE5, RULE11
         pwm2 <= rollover_q ? ({u2_active, u2_lat} != 10'h000) : (pwm2 && !m2_clr);
         // Compare pin: initial level on mode write, action on match
         if (wr && addr == `CPM_A_U1_CTRL)
            cmp1 <= (wdata[3:0] == `CPM_M_CMP_CLR);                     // see RULE19
         else if (hit1 && mode1 == `CPM_M_CMP_TOGGLE)
            cmp1 <= !cmp1;
         else if (hit1 && mode1 == `CPM_M_CMP_SET)
            cmp1 <= 1'b1;
         else if (hit1 && mode1 == `CPM_M_CMP_CLR)
            cmp1 <= 1'b0;
         if (wr && addr == `CPM_A_U2_CTRL)
            cmp2 <= (wdata[3:0] == `CPM_M_CMP_CLR);
         else if (hit2 && mode2 == `CPM_M_CMP_TOGGLE)
            cmp2 <= !cmp2;
         else if (hit2 && mode2 == `CPM_M_CMP_SET)
            cmp2 <= 1'b1;
         else if (hit2 && mode2 == `CPM_M_CMP_CLR)
            cmp2 <= 1'b0;
         // Flags: a new event wins over a software clear
         if (hit1 || cap1)
            match_flag1 <= 1'b1;                                        // see RULE19
         else if (wr && addr == `CPM_A_STATUS && wdata[0])
            match_flag1 <= 1'b0;
         if (hit2 || cap2)
            match_flag2 <= 1'b1;
         else if (wr && addr == `CPM_A_STATUS && wdata[1])
            match_flag2 <= 1'b0;
         special_event <= (hit1 && mode1 == `CPM_M_CMP_TRIG) || (hit2 && mode2 == `CPM_M_CMP_TRIG);
         // Dead band counted in instruction cycles from each edge
         pwm1_q <= pwm1;
         rollover_q <= rollover;
         if (pwm1 != pwm1_q)
            db_cnt <= 7'h00;                                            // see RULE22
         else if (instr_tick && db_cnt != 7'h7F)
            db_cnt <= db_cnt + 7'h01;
      end
   end
   // ------------------------------------------------------------
   // Output steering and polarity, registered
   // ------------------------------------------------------------
   wire [6:0] db_len = deadband_delay[`CPM_F_DB_HI:`CPM_F_DB_LO];
   wire       db_ok  = (pwm1 == pwm1_q) && (db_cnt >= db_len);
   wire       pa = (ocfg == `CPM_OC_HALF) ? (pwm1 && db_ok) :
                   (ocfg == `CPM_OC_FWD)  ? 1'b1 :
                   (ocfg == `CPM_OC_REV)  ? 1'b0 : pwm1;
   wire       pb = (ocfg == `CPM_OC_HALF) ? (!pwm1 && db_ok) :
                   (ocfg == `CPM_OC_REV)  ? pwm1 : 1'b0;
   wire       pc = (ocfg == `CPM_OC_REV);
   wire       pd = (ocfg == `CPM_OC_FWD) ? pwm1 : 1'b0;
   wire       kill = sd_active;
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         output_a <= 1'b0;
         output_b <= 1'b0;
         output_c <= 1'b0;
         output_d <= 1'b0;
         out_en <= 4'h0;
         unit2_out <= 1'b0;
         unit2_en <= 1'b0;
      end else begin
         if (pwm_mode1) begin
            // Shutdown forces every output to its inactive level
            output_a <= (pa && !kill) ^ mode1[1];                       // see RULE16
            output_b <= (pb && !kill) ^ mode1[0];                       // see RULE21
            output_c <= (pc && !kill) ^ mode1[1];
            output_d <= (pd && !kill) ^ mode1[0];
            out_en <= {ocfg[0], ocfg[0], ocfg != `CPM_OC_SINGLE, 1'b1};
         end else begin
            output_a <= cmp1;                                           // see RULE15
            output_b <= 1'b0;
            output_c <= 1'b0;
            output_d <= 1'b0;
            out_en <= {3'h0, cmp_is1 && mode1 != `CPM_M_CMP_SOFT};      // see RULE20
         end
         // Second unit has no shutdown path at all
         unit2_out <= pwm_mode2 ? pwm2 : cmp2;                          // see RULE12
         unit2_en <= pwm_mode2 || (cmp_is2 && mode2 != `CPM_M_CMP_SOFT);
      end
   end
   // ------------------------------------------------------------
   // Register read port, data one cycle after strobe
   // ------------------------------------------------------------
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn)
         rdata <= 8'h00;
      else if (rd) begin
         case (addr)
            `CPM_A_TB_COUNT:  rdata <= timebase_counter;
            `CPM_A_PERIOD:    rdata <= period_limit;
            `CPM_A_TB_CTRL:   rdata <= timebase_control;
            `CPM_A_U1_NEXT:   rdata <= u1_next;
            `CPM_A_U1_ACTIVE: rdata <= u1_active;
            `CPM_A_U1_CTRL:   rdata <= u1_ctrl;
            `CPM_A_U2_NEXT:   rdata <= u2_next;
            `CPM_A_U2_ACTIVE: rdata <= u2_active;
            `CPM_A_U2_CTRL:   rdata <= u2_ctrl;
            `CPM_A_SHUTDOWN:  rdata <= shutdown_control;
            `CPM_A_DEADBAND:  rdata <= deadband_delay;
            `CPM_A_CAPT_LO:   rdata <= capture_timer[7:0];
            `CPM_A_CAPT_HI:   rdata <= capture_timer[15:8];
            `CPM_A_STATUS:    rdata <= {6'h00, match_flag2, match_flag1};
            default:          rdata <= 8'h00;
         endcase
      end else
         rdata <= 8'h00;
   end
endmodule // cpm_pwm_mode_control
`default_nettype wire

// ==== testbench/cpm_load_model.sv ====
// Load model on one PWM pin: measures high time and period in clocks.
// Assumes the pin is a registered output that changes on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module cpm_load_model (
   input  wire logic        ref_clk,
   input  wire logic        pin,
   output var  logic [15:0] high_len,
   output var  logic [15:0] per_len
);
   logic        last = 1'b0;
   logic [15:0] cnt  = 16'h0000;
   // A load only sees levels, it never answers; count from each rise
   always @(posedge ref_clk) begin
      last <= pin;
      cnt  <= (pin && !last) ? 16'h0001 : cnt + 16'h0001;
      if (!pin && last)
         high_len <= cnt;
      if (pin && !last)
         per_len <= cnt;
   end
endmodule // cpm_load_model
`default_nettype wire

// ==== testbench/cpm_pwm_sva.sv ====
// Checker: register port and output steering of the PWM block.
// Assumes a bind onto the block's top module; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module cpm_pwm_sva (
   input wire logic       ref_clk,
   input wire logic       rstn,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       output_a,
   input wire logic       output_b,
   input wire logic       output_c,
   input wire logic       output_d,
   input wire logic [3:0] out_en
);
   logic [7:0]  ctl;
   logic [7:0]  per;
   logic [10:0] age;
   // Shadows; steering may wait for a period boundary, so age gates it
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ctl <= 8'h00;
         per <= 8'hFF;
         age <= 11'h000;
      end else begin
         ctl <= (wr && addr == 4'h5) ? wdata : ctl;
         per <= (wr && addr == 4'h1) ? wdata : per;
         age <= (wr && addr == 4'h5) ? 11'h000 : ((age == 11'h7FF) ? age : age + 11'h001);
      end
   end
   wire pwm = ctl[3:2] == 2'h3;
   wire old = age > 11'h5DC;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   rd_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("rdata not zero outside a read");
   unmapped_a: assert property (rd && addr > 4'hD |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   ctrl_rb_a: assert property (rd && addr == 4'h5 |=> rdata == $past(ctl))
      else $error("mode control readback wrong");
   period_rb_a: assert property (rd && addr == 4'h1 |=> rdata == $past(per))
      else $error("period readback wrong");
   port_pins_a: assert property (!pwm && old |-> out_en[3:1] == 3'h0)
      else $error("B C D not released outside PWM");
   single_out_a: assert property (pwm && old && ctl[7:6] == 2'h0 |-> out_en[3:1] == 3'h0)
      else $error("single output drives B C D");
   half_out_a: assert property (pwm && old && ctl[7:6] == 2'h2 |-> out_en == 4'h3)
      else $error("half bridge enables wrong");
   fwd_out_a: assert property (pwm && old && ctl[7:6] == 2'h1
      |-> out_en == 4'hF && output_a == !ctl[1] && output_b == ctl[0] && output_c == ctl[1])
      else $error("forward bridge levels wrong");
   rev_out_a: assert property (pwm && old && ctl[7:6] == 2'h3
      |-> out_en == 4'hF && output_a == ctl[1] && output_d == ctl[0] && output_c == !ctl[1])
      else $error("reverse bridge levels wrong");
   cover property (pwm && old && ctl[7:6] == 2'h1);
   cover property (pwm && old && ctl[7:6] == 2'h2);
   cover property (pwm && old && ctl[7:6] == 2'h3);
endmodule // cpm_pwm_sva
bind cpm_pwm_mode_control cpm_pwm_sva cpm_pwm_sva_inst (.ref_clk, .rstn, .addr, .wdata, .wr, .rd, .rdata,
   .output_a, .output_b, .output_c, .output_d, .out_en);
`default_nettype wire

// ==== testbench/cpm_pwm_mode_control_bench.sv ====
// Bench: programs the PWM through its register port and times the pin.
// Assumes the block, load model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module cpm_pwm_mode_control_bench;
   logic        ref_clk, rstn, wr, rd, o_a, o_u2, u2_en;
   logic [3:0]  addr;
   logic [7:0]  wdata, rdata, p;
   logic [9:0]  d;
   logic [15:0] hl, pl;
   logic [31:0] seed = 32'h0000E83D;
   int          err_count = 0;
   int          checks = 0;
   int          per, bad;
   cpm_pwm_mode_control cpm_pwm_mode_control_inst (.ref_clk, .rstn, .addr, .wdata, .wr, .rd, .rdata,
      .capt_pin1(1'b0), .capt_pin2(1'b0), .shutdown_in(1'b0), .output_a(o_a), .output_b(), .output_c(),
      .output_d(), .out_en(), .unit2_out(o_u2), .unit2_en(u2_en), .match_flag1(), .match_flag2(), .special_event());
   cpm_load_model cpm_load_model_inst (.ref_clk, .pin(o_a), .high_len(hl), .per_len(pl));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic int ps(int s);
      return (s == 0) ? 1 : ((s == 1) ? 4 : 16);
   endfunction
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      checks++;
      if (s !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Gap cycle after each strobe keeps one assignment per time step
   task automatic wreg(input logic [3:0] a, input logic [7:0] v);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rchk(input logic [3:0] a, input logic [7:0] e);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 chk("rdata", {8'h00, e}, {8'h00, rdata});
      @(posedge ref_clk);
   endtask
   task automatic results();
      if (err_count == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // Watchdog well beyond the longest sequence
   initial begin
      #300000;
      err_count++;
      results();
   end
   initial begin
      {rstn, wr, rd, addr, wdata} = '0;
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      rchk(4'h5, 8'h00);
      rchk(4'h1, 8'hFF);
      rchk(4'hE, 8'h00);
      // One pass per prescale, stopped and cleared timebase each time
      for (int s = 0; s < 3; s++) begin
         p = 8'(xs() % 18) + 8'h03;
         d = 10'(xs() % (4 * (p + 1) - 1)) + 10'h001;
         per = (p + 1) * 4 * ps(s);
         wreg(4'h2, 8'h00);
         wreg(4'h0, 8'h00);
         wreg(4'h1, p);
         wreg(4'h3, d[9:2]);
         wreg(4'h5, {2'h0, d[1:0], 4'h0});
         wreg(4'h2, {5'h00, 1'b1, 2'(s)});
         wreg(4'h5, {2'h0, d[1:0], 4'hC});
         repeat (4 * per + 20) @(posedge ref_clk);
         chk("period", 16'(per), pl);
         chk("high", 16'(d * ps(s)), hl);
         rchk(4'h4, d[9:2]);
         wreg(4'h4, ~d[9:2]);
         rchk(4'h4, d[9:2]);
      end
      // Duty beyond the period holds high; zero duty never rises
      for (int v = 1; v >= 0; v--) begin
         wreg(4'h3, v ? 8'hFF : 8'h00);
         wreg(4'h5, v ? 8'h3C : 8'h0C);
         wreg(4'h6, v ? 8'hFF : 8'h00);
         wreg(4'h8, v ? 8'h3C : 8'h0C);
         repeat (2 * per) @(posedge ref_clk);
         bad = 0;
         repeat (per) @(posedge ref_clk) bad += (o_a !== 1'(v)) + (o_u2 !== 1'(v)) + (u2_en !== 1'b1);
         chk("level", 16'h0000, 16'(bad));
      end
      // Every steering mode with random polarity, judged by the checker
      for (int oc = 0; oc < 4; oc++) begin
         wreg(4'h5, {2'(oc), 2'h2, 2'h3, 2'(xs())});
         repeat (1600) @(posedge ref_clk);
      end
      wreg(4'h5, 8'h00);
      repeat (1600) @(posedge ref_clk);
      rchk(4'hD, 8'h00);
      results();
   end
endmodule // cpm_pwm_mode_control_bench
`default_nettype wire
